// ==== common/dits_map.vh ====
// Purpose: constants for the dual-ID two-wire slave front end
// Assumes: bit positions count from the least significant bit
// Notes:   included by rtl/dits_slave.v only
//
// Summary of operation
// R1 - Device is always a slave; the master makes every clock.
// R2 - Start (SDA falls, SCL high) aborts everything; expect a slave address.
// R3 - Stop (SDA rises, SCL high) aborts anything pending; go idle.
// R4 - Master gives Stop only while it owns SDA, never during read data.
// R5 - Bits sampled while SCL high; SDA steady then except Start/Stop.
// R6 - After bit eight transmitter releases; receiver pulls low; high is NACK.
// R7 - First byte after Start is the slave address byte.
// R8 - Slave address bits 7-4 equal 1010b select the memory slave.
// R9 - Slave address bits 7-4 equal 1101b select the clock register slave.
// R10 - Clock register transactions never change memory contents.
// R11 - Master sends slave address bits 3 to 1 as zero.
// R12 - Slave address bit 0: one is read, zero is write.
// R13 - Memory write sends upper then lower address byte; latched as address.
// R14 - Top three bits of the upper memory address byte are ignored.
// R15 - Address increments per data byte before its ACK; wraps to zero.
// R16 - Current memory address kept between transactions until rewritten.
// R17 - Clock register transactions leave the memory address untouched.
// R18 - Reads start at current address; random read is write then restart.
// R19 - Any number of bytes per transaction, no length limit.
// R20 - One register address byte; 00h-0Eh valid, higher is NACKed, aborted.
// R21 - Read: shift eight bits, sample ACK; ACK sends next, NACK ends.
// R22 - Write: take eight bits, drive ACK; all bytes MSB first.
// R23 - Snapshot bit set to one freezes counters into user time registers.
// R24 - Write-hold one blocks time writes; clearing it loads the counters.
// R25 - Unmatched slave ID: no ACK, ignore bus until next Start.
// R26 - Register address auto-increments per byte like the memory address.
// R27 - Separate memory and register pointers; one never disturbs the other.
`ifndef DITS_MAP_VH
`define DITS_MAP_VH

// ****************************************
// Slave identities and address fields
// ****************************************
`define DITS_ID_MEM      4'h_A
`define DITS_ID_REG      4'h_D
`define DITS_REG_LAST    4'h_E
`define DITS_REG_CTRL    4'h_0
`define DITS_SNAP_BIT    0
`define DITS_HOLD_BIT    1
`define DITS_HI_BITS     5
`define DITS_RD_LATENCY  2'h_1

`endif

// ==== dv/dits_checker.sv ====
// Purpose: port-level checks on the two-wire slave
// Assumes: SYS_CLK far faster than SCL_I
// Notes:   bound to dits_slave at the foot
`timescale 1ns/1ps
module dits_checker #(parameter AW = 13) (
	// Clock, reset and pins
	input wire logic          SYS_CLK,
	input wire logic          RST,
	input wire logic          SCL_I,
	input wire logic          SDA_I,
	input wire logic          SDA_OE_N,
	// Streams and time control
	input wire logic          WR_VALID,
	input wire logic          WR_READY,
	input wire logic          WR_SEL,
	input wire logic [AW-1:0] WR_ADDR,
	input wire logic [7:0]    WR_DATA,
	input wire logic          RD_REQ,
	input wire logic          RD_SEL,
	input wire logic [AW-1:0] RD_ADDR,
	input wire logic          TIME_SNAP,
	input wire logic          TIME_HOLD,
	input wire logic          TIME_LOAD
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Stop on the pins, then a quiet spell
	sequence s_stop;
		SCL_I && $rose(SDA_I);
	endsequence
	sequence s_quiet;
		(SDA_OE_N && !RD_REQ) [*4];
	endsequence
	a_drive_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_I)
		else $error("drive moved while SCL high");
	a_stop_idle: assert property (s_stop |=> ##3 s_quiet)
		else $error("activity after stop");
	a_push_scl_high: assert property ($rose(WR_VALID) |-> SCL_I && $past(SCL_I, 2))
		else $error("write push off the eighth rise");
	a_stall_hold: assert property (WR_VALID && !WR_READY |=> WR_VALID &&
		$stable({WR_SEL, WR_ADDR, WR_DATA})) else $error("stalled head changed");
	a_req_once: assert property (RD_REQ |=> !RD_REQ && $stable({RD_SEL, RD_ADDR}))
		else $error("read request not a clean pulse");
	a_req_scl_high: assert property (RD_REQ |-> SCL_I)
		else $error("read request off the ack rise");
	a_reg_rd_range: assert property (RD_REQ && RD_SEL |-> RD_ADDR < 15)
		else $error("register read above last");
	a_reg_wr_range: assert property (WR_VALID && WR_SEL |-> WR_ADDR < 15)
		else $error("register write above last");
	a_snap_pulse: assert property (TIME_SNAP |-> SCL_I ##1 !TIME_SNAP)
		else $error("snapshot pulse bad");
	a_load_clears: assert property (TIME_LOAD |-> !TIME_HOLD && $past(TIME_HOLD))
		else $error("load without hold falling");
endmodule // dits_checker
bind dits_slave dits_checker #(.AW(AW)) u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
	.SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_OE_N(SDA_OE_N), .WR_VALID(WR_VALID),
	.WR_READY(WR_READY), .WR_SEL(WR_SEL), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
	.RD_REQ(RD_REQ), .RD_SEL(RD_SEL), .RD_ADDR(RD_ADDR), .TIME_SNAP(TIME_SNAP),
	.TIME_HOLD(TIME_HOLD), .TIME_LOAD(TIME_LOAD));

// ==== dv/dits_master.sv ====
// Purpose: behavioural two-wire bus master
// Assumes: 160 ns SCL period, pull-up on SDA
// Notes:   SCL rests high between frames
`timescale 1ns/1ps
module dits_master (
	// Bus pins
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// Idle bus
	initial begin
		scl = 1;
		sda_low = 0;
	end
	// One bit: set while SCL low, sampled mid-high
	task automatic bit_cyc(input logic drive_low, output logic seen);
		sda_low = drive_low;
		#40 scl = 1;
		#40 seen = sda;
		#40 scl = 0;
		#40;
	endtask
	task automatic start;
		sda_low = 0;
		#40 scl = 1;
		#40 sda_low = 1;
		#40 scl = 0;
		#40;
	endtask
	// Only issued while the master owns SDA
	task automatic stop;
		sda_low = 1;
		#40 scl = 1;
		#40 sda_low = 0;
		#80;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cyc(!d[i], s);
		bit_cyc(0, s);
		ack = !s;
	endtask
	task automatic rd(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cyc(0, d[i]);
		bit_cyc(ack, s);
	endtask
endmodule // dits_master

// ==== dv/dual_id_two_wire_slave_bench.sv ====
// Purpose: self-checking bench for the two-wire slave
// Assumes: pull-up on SDA; master model makes SCL
// Notes:   far-end store is modelled in arrays
`timescale 1ns/1ps
module dual_id_two_wire_slave_bench;
	logic       sys_clk = 0;
	logic       rst = 1;
	logic       wr_ready = 1;
	logic [7:0] rd_data = 8'h00;
	logic       m_low;
	logic       scl;
	wire        sda_oe_n, wr_valid, wr_sel, rd_req, rd_sel, time_snap, time_hold, time_load;
	wire [12:0] wr_addr, rd_addr;
	wire [7:0]  wr_data;
	wire        sda = !(m_low || !sda_oe_n);
	logic [7:0] mem [0:8191];
	logic [7:0] regs [0:15];
	int         n_checks = 0, error_cnt = 0, n_snap = 0, n_load = 0;
	always #5 sys_clk = ~sys_clk;
	dits_slave dut (.SYS_CLK(sys_clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
		.SDA_OE_N(sda_oe_n), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_SEL(wr_sel),
		.WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_REQ(rd_req), .RD_SEL(rd_sel),
		.RD_ADDR(rd_addr), .RD_DATA(rd_data), .TIME_SNAP(time_snap),
		.TIME_HOLD(time_hold), .TIME_LOAD(time_load));
	dits_master m (.scl(scl), .sda_low(m_low), .sda(sda));
	// Far-end store: take the write stream, answer reads a cycle later
	always @(posedge sys_clk) begin
		if (wr_valid && wr_ready) begin
			if (wr_sel) regs[wr_addr[3:0]] = wr_data;
			else mem[wr_addr] = wr_data;
		end
		if (rd_req) rd_data <= #1 (rd_sel ? regs[rd_addr[3:0]] : mem[rd_addr]);
		n_snap += time_snap;
		n_load += time_load;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Leave the bus off the clock edges
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		logic a;
		m.wr(d, a);
		chk("ack", a, e);
	endtask
	task automatic rb(input logic ack, input logic [7:0] e);
		logic [7:0] d;
		m.rd(ack, d);
		chk("read", d, e);
	endtask
	task automatic wreg(input logic [7:0] a, d);
		m.start();
		wb(8'hD0, 1);
		wb(a, 1);
		wb(d, 1);
		m.stop();
		idle(20);
	endtask
	task automatic t_mem_write;
		m.start();
		wb(8'hA0, 1);
		wb(8'hFF, 1);
		wb(8'hFF, 1);
		wb(8'h5A, 1);
		wb(8'hC3, 1);
		m.stop();
		idle(20);
		chk("mem_top", mem[8191], 8'h5A);
		chk("mem_wrap", mem[0], 8'hC3);
	endtask
	task automatic t_regs;
		wreg(8'h05, 8'h11);
		chk("reg5", regs[5], 8'h11);
		chk("mem5", mem[5], 8'h39);
		m.start();
		wb(8'hD0, 1);
		wb(8'h0F, 0);
		m.stop();
		m.start();
		wb(8'hA1, 1);
		rb(1, 8'h3D);
		rb(0, 8'h3E);
		m.stop();
		m.start();
		wb(8'hD0, 1);
		wb(8'h04, 1);
		m.start();
		wb(8'hD1, 1);
		rb(1, 8'h44);
		rb(0, 8'h11);
		m.stop();
		idle(4);
	endtask
	task automatic t_bad_id;
		m.start();
		wb(8'h90, 0);
		wb(8'hA0, 0);
		m.stop();
		idle(4);
	endtask
	// Far side stalls until the buffer refuses
	task automatic t_stall;
		wr_ready = 0;
		m.start();
		wb(8'hA0, 1);
		wb(8'h00, 1);
		wb(8'h10, 1);
		wb(8'h01, 1);
		wb(8'h02, 1);
		wb(8'h03, 0);
		m.stop();
		idle(1);
		chk("held", wr_valid, 1);
		wr_ready = 1;
		idle(8);
		chk("drained", wr_valid, 0);
		chk("mem10", mem[16], 8'h01);
		chk("mem11", mem[17], 8'h02);
		chk("mem12", mem[18], 8'h2E);
	endtask
	task automatic t_time;
		wreg(8'h00, 8'h01);
		chk("snap", n_snap, 1);
		wreg(8'h00, 8'h02);
		chk("hold", time_hold, 1);
		wreg(8'h00, 8'h00);
		chk("hold_off", time_hold, 0);
		chk("load", n_load, 1);
	endtask
	// Register pointer wraps from the last register back to the first
	task automatic t_reg_wrap;
		m.start();
		wb(8'hD0, 1);
		wb(8'h0E, 1);
		wb(8'h77, 1);
		m.start();
		wb(8'hD1, 1);
		rb(0, 8'h00);
		m.stop();
		idle(4);
		chk("reg14", regs[14], 8'h77);
	endtask
	// Main sequence
	initial begin
		for (int k = 0; k < 8192; k++) mem[k] = k[7:0] ^ 8'h3C;
		for (int k = 0; k < 16; k++) regs[k] = k[7:0] + 8'h40;
		repeat (16) @(posedge sys_clk);
		#1 rst = 0;
		idle(4);
		t_mem_write();
		t_regs();
		t_bad_id();
		t_stall();
		t_time();
		t_reg_wrap();
		print_verdict();
	end
	// Watchdog: about four times the expected run
	initial begin
		#250000;
		error_cnt++;
		print_verdict();
	end
endmodule // dual_id_two_wire_slave_bench

// ==== rtl/dits_slave.v ====
// Purpose: two-wire slave front end exposing a memory and a clock register slave
// Assumes: SCL and SDA are asynchronous pins; SYS_CLK is far faster than SCL
// Notes:   SDA is open drain; SDA_OE_N low pulls the line low
`timescale 1ns/1ps
`include "dits_map.vh"

module dits_slave #(
	parameter AW = 13,
	parameter BUF_W = 22
) (
	// Clock and reset
	input  wire          SYS_CLK,
	input  wire          RST,
	// Two-wire pins
	input  wire          SCL_I,
	input  wire          SDA_I,
	output wire          SDA_O,
	output wire          SDA_OE_N,
	// Write stream: {SEL, ADDR, DATA}
	output wire          WR_VALID,
	input  wire          WR_READY,
	output wire          WR_SEL,
	output wire [AW-1:0] WR_ADDR,
	output wire [7:0]    WR_DATA,
	// Read request and returned data
	output reg           RD_REQ,
	output reg           RD_SEL,
	output reg  [AW-1:0] RD_ADDR,
	input  wire [7:0]    RD_DATA,
	// Time register control
	output reg           TIME_SNAP,
	output wire          TIME_HOLD,
	output reg           TIME_LOAD
);

	// ****************************************
	// States
	// ****************************************
	localparam ST_IDLE = 3'h_0;
	localparam ST_DEV  = 3'h_1;
	localparam ST_AHI  = 3'h_2;
	localparam ST_ALO  = 3'h_3;
	localparam ST_RADR = 3'h_4;
	localparam ST_WDAT = 3'h_5;
	localparam ST_RDAT = 3'h_6;
	localparam ST_IGN  = 3'h_7;

	// ****************************************
	// Pin synchronisers and bus events
	// ****************************************
	reg [2:0] scl_sync_reg;
	reg [2:0] sda_sync_reg;
	wire      scl_s;
	wire      sda_s;
	wire      scl_rise;
	wire      scl_fall;
	wire      bus_start;
	wire      bus_stop;

	// Two flops per pin, third stage only for edge detection
	always @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			scl_sync_reg <= 3'h_7;
			sda_sync_reg <= 3'h_7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
			sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
		end
	end

	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s & ~scl_sync_reg[2];
	assign scl_fall  = ~scl_s & scl_sync_reg[2];
	// Start and stop: SDA moves while SCL high
	assign bus_start = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2]; // R2
	assign bus_stop  = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2]; // R3

	// ****************************************
	// Protocol registers
	// ****************************************
	reg [2:0]          state_reg;
	reg [3:0]          bit_cnt_reg;
	reg [6:0]          rx_reg;
	reg [7:0]          tx_reg;
	reg                ack_reg;
	reg                drive_low_reg;
	reg                sel_reg;
	reg [4:0]          hi_reg;
	reg [AW-1:0]       mem_ptr_reg;
	reg [3:0]          reg_ptr_reg;
	reg                hold_reg;
	reg                snap_bit_reg;
	reg [1:0]          rd_wait_reg;
	reg [7:0]          rd_hold_reg;
	reg                push_reg;
	reg [BUF_W-1:0]    push_data_reg;
	wire [7:0]         byte_in;
	wire               buf_ready;
	wire [AW-1:0]      cur_ptr;

	assign byte_in = {rx_reg, sda_s};
	assign cur_ptr = sel_reg ? {{(AW-4){1'b0}}, reg_ptr_reg} : mem_ptr_reg;

	// Register pointer steps and wraps after the last register
	function [3:0] reg_step;
		input [3:0] p;
		begin
			reg_step = (p == `DITS_REG_LAST) ? 4'h_0 : p + 4'h_1;
		end
	endfunction

	// ****************************************
	// Main sequencer on synchronised SCL edges
	// ****************************************
	always @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_reg     <= ST_IDLE;
			bit_cnt_reg   <= 4'h_0;
			rx_reg        <= 7'h_00;
			tx_reg        <= 8'h_FF;
			ack_reg       <= 1'b0;
			drive_low_reg <= 1'b0;
			sel_reg       <= 1'b0;
			hi_reg        <= 5'h_00;
			mem_ptr_reg   <= {AW{1'b0}};
			reg_ptr_reg   <= 4'h_0;
			hold_reg      <= 1'b0;
			snap_bit_reg  <= 1'b0;
			RD_REQ        <= 1'b0;
			RD_SEL        <= 1'b0;
			RD_ADDR       <= {AW{1'b0}};
			TIME_SNAP     <= 1'b0;
			TIME_LOAD     <= 1'b0;
			push_reg      <= 1'b0;
			push_data_reg <= {BUF_W{1'b0}};
		end else begin
			RD_REQ    <= 1'b0;
			TIME_SNAP <= 1'b0;
			TIME_LOAD <= 1'b0;
			push_reg  <= 1'b0;
			if (bus_start) begin
				// Abort anything and wait for an address byte
				state_reg     <= ST_DEV; // R2 R7
				bit_cnt_reg   <= 4'h_0;
				drive_low_reg <= 1'b0;
				ack_reg       <= 1'b0;
			end else if (bus_stop) begin
				state_reg     <= ST_IDLE; // R3
				bit_cnt_reg   <= 4'h_0;
				drive_low_reg <= 1'b0;
				ack_reg       <= 1'b0;
			end else if (scl_rise && state_reg != ST_IDLE && state_reg != ST_IGN) begin
				if (bit_cnt_reg == 4'h_8) begin
					// Ninth clock: acknowledge slot
					bit_cnt_reg <= 4'h_0;
					if (state_reg == ST_RDAT) begin
						if (!sda_s) begin
							// Master ACK (or our own address ACK): fetch next
							RD_REQ  <= 1'b1; // R21
							RD_SEL  <= sel_reg;
							RD_ADDR <= cur_ptr; // R18
						end else begin
							state_reg <= ST_IGN; // R21 R6
						end
					end
				end else begin
					// Data bits sampled while SCL is high, MSB first
					rx_reg      <= byte_in[6:0]; // R5 R22
					bit_cnt_reg <= bit_cnt_reg + 4'h_1;
					if (bit_cnt_reg == 4'h_7) begin
						ack_reg <= 1'b1;
						case (state_reg)
							ST_DEV: begin
								// Bits 3..1 are not checked; only ID and direction
								if (byte_in[7:4] == `DITS_ID_MEM ||
										byte_in[7:4] == `DITS_ID_REG) begin // R8 R9 R11
									sel_reg <= (byte_in[7:4] == `DITS_ID_REG);
									if (byte_in[0])
										state_reg <= ST_RDAT; // R12
									else if (byte_in[7:4] == `DITS_ID_REG)
										state_reg <= ST_RADR;
									else
										state_reg <= ST_AHI; // R13
								end else begin
									ack_reg   <= 1'b0;
									state_reg <= ST_IGN; // R25
								end
							end
							ST_AHI: begin
								hi_reg    <= byte_in[`DITS_HI_BITS-1:0]; // R14
								state_reg <= ST_ALO;
							end
							ST_ALO: begin
								mem_ptr_reg <= {hi_reg, byte_in}; // R13 R16
								state_reg   <= ST_WDAT;
							end
							ST_RADR: begin
								if (byte_in <= {4'h_0, `DITS_REG_LAST}) begin
									reg_ptr_reg <= byte_in[3:0]; // R27
									state_reg   <= ST_WDAT;
								end else begin
									ack_reg   <= 1'b0;
									state_reg <= ST_IGN; // R20
								end
							end
							ST_WDAT: begin
								if (buf_ready) begin
									// Only the selected slave's pointer moves
									push_reg      <= 1'b1;
									push_data_reg <= {sel_reg, cur_ptr, byte_in}; // R10
									if (sel_reg)
										reg_ptr_reg <= reg_step(reg_ptr_reg); // R26 R17
									else
										mem_ptr_reg <= mem_ptr_reg + 1'b1; // R15
									if (sel_reg && reg_ptr_reg == `DITS_REG_CTRL) begin
										snap_bit_reg <= byte_in[`DITS_SNAP_BIT];
										hold_reg     <= byte_in[`DITS_HOLD_BIT];
										// Rising snapshot bit freezes counters
										TIME_SNAP <= byte_in[`DITS_SNAP_BIT] & ~snap_bit_reg; // R23
										// Falling hold bit transfers registers
										TIME_LOAD <= hold_reg & ~byte_in[`DITS_HOLD_BIT]; // R24
									end
								end else begin
									// Full buffer: refuse the byte rather than lose it
									ack_reg   <= 1'b0;
									state_reg <= ST_IGN;
								end
							end
							ST_RDAT: begin
								// Byte sent; step before the ACK slot
								ack_reg <= 1'b0;
								if (sel_reg)
									reg_ptr_reg <= reg_step(reg_ptr_reg); // R26
								else
									mem_ptr_reg <= mem_ptr_reg + 1'b1; // R15 R19
							end
							default: begin
								ack_reg <= 1'b0;
							end
						endcase
					end
				end
			end else if (scl_fall) begin
				// SDA only changes while SCL is low
				if (bit_cnt_reg == 4'h_8) begin
					drive_low_reg <= ack_reg; // R6 R22
				end else if (bit_cnt_reg == 4'h_0 && state_reg == ST_RDAT) begin
					tx_reg        <= rd_hold_reg;
					drive_low_reg <= ~rd_hold_reg[7]; // R21
				end else if (state_reg == ST_RDAT && bit_cnt_reg != 4'h_0) begin
					tx_reg        <= {tx_reg[6:0], 1'b1};
					drive_low_reg <= ~tx_reg[6];
				end else begin
					drive_low_reg <= 1'b0; // R6
				end
			end
		end
	end

	// ****************************************
	// Read data capture, fixed latency
	// ****************************************
	always @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rd_wait_reg <= 2'h_0;
			rd_hold_reg <= 8'h_FF;
		end else begin
			if (RD_REQ)
				rd_wait_reg <= `DITS_RD_LATENCY;
			else if (rd_wait_reg != 2'h_0)
				rd_wait_reg <= rd_wait_reg - 2'h_1;
			if (rd_wait_reg == 2'h_1)
				rd_hold_reg <= RD_DATA;
		end
	end

	// ****************************************
	// Two-entry write buffer
	// ****************************************
	reg [BUF_W-1:0] buf_mem [0:1];
	reg             buf_wp_reg;
	reg             buf_rp_reg;
	reg [1:0]       buf_cnt_reg;
	wire            pop;

	assign pop       = WR_VALID & WR_READY;
	assign buf_ready = (buf_cnt_reg == 2'h_0) ||
		(buf_cnt_reg == 2'h_1 && !push_reg);

	// Push and pop may meet; count tracks both
	always @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_cnt_reg <= 2'h_0;
			buf_mem[0]  <= {BUF_W{1'b0}};
			buf_mem[1]  <= {BUF_W{1'b0}};
		end else begin
			if (push_reg) begin
				buf_mem[buf_wp_reg] <= push_data_reg;
				buf_wp_reg          <= ~buf_wp_reg;
			end
			if (pop)
				buf_rp_reg <= ~buf_rp_reg;
			if (push_reg && !pop)
				buf_cnt_reg <= buf_cnt_reg + 2'h_1;
			else if (pop && !push_reg)
				buf_cnt_reg <= buf_cnt_reg - 2'h_1;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign WR_VALID  = (buf_cnt_reg != 2'h_0);
	assign WR_SEL    = buf_mem[buf_rp_reg][BUF_W-1];
	assign WR_ADDR   = buf_mem[buf_rp_reg][AW+7:8];
	assign WR_DATA   = buf_mem[buf_rp_reg][7:0];
	assign TIME_HOLD = hold_reg; // R24
	// Open drain: never drives high, slave only
	assign SDA_O     = 1'b0; // R1
	assign SDA_OE_N  = ~drive_low_reg;

endmodule // dits_slave
